// [rtl/ibto_top.sv]
// Purpose: Bus idle timeout of an I2C controller with register port and interrupt.
// Assumes: bus_busy and presc_tick come from the engine on clk.
// Notes: SCL arrives from the pin and is synchronised here.
// Summary of operation
// - go-idle set plus timeout forces bus idle
// - while busy, SCL rising restarts timer
// - timer reaching selected count sets flag
// - flag set again each period SCL high
// - timeout active only while bus busy
// - go-idle set stops timeout after expiry
// - abort command stops the timeout
// - select 0 off, 1/2/3 give 40/80/160
//
// Local design decisions: the register offsets and strobed register access.
`default_nettype none
module ibto_top
   import ibto_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   // Engine side
   input wire logic presc_tick,
   input wire logic bus_busy,
   input wire logic scl_in,
   output logic force_idle,
   output logic abort_cmd,
   // Interrupt
   output logic irq
);
   logic scl_s;
   logic scl_prev_q;
   logic [DATA_W-1:0] ctrl_q;
   logic [IRQ_W-1:0] flags_q;
   logic [IRQ_W-1:0] mask_q;
   logic [IRQ_W-1:0] flags_d;
   logic [IRQ_W-1:0] set_ev;
   logic [DATA_W-1:0] rd_mux;
   ibto_state_t state_q;
   ibto_state_t state_d;
   logic go_idle_en;
   logic [1:0] sel;
   logic [CNT_W-1:0] limit;
   logic timer_run;
   logic scl_rise;
   logic expire;
   logic wr_ctrl;
   logic wr_flags;
   logic wr_mask;
   logic wr_abort;

   function automatic logic [CNT_W-1:0] sel_limit(input logic [1:0] s);
      case (s)
         SEL_SHORT: sel_limit = TIMEOUT_SHORT;
         SEL_MEDIUM: sel_limit = TIMEOUT_MEDIUM;
         SEL_LONG: sel_limit = TIMEOUT_LONG;
         default: sel_limit = '0;
      endcase
   endfunction

   ibto_sync u_scl_sync (
      .clk(clk),
      .nrst(nrst),
      .async_in(scl_in),
      .sync_out(scl_s)
   );

   assign wr_ctrl = reg_wr && (reg_addr == OFF_CTRL);
   assign wr_flags = reg_wr && (reg_addr == OFF_IRQ_FLAGS);
   assign wr_mask = reg_wr && (reg_addr == OFF_IRQ_MASK);
   assign wr_abort = reg_wr && (reg_addr == OFF_CMD) && reg_wdata[CMD_ABORT_BIT];
   assign go_idle_en = ctrl_q[CTRL_GO_IDLE_BIT];
   assign sel = ctrl_q[CTRL_SEL_MSB:CTRL_SEL_LSB];
   assign limit = sel_limit(sel);
   assign scl_rise = scl_s && !scl_prev_q;
   // Timer only counts while SCL is high and the timeout is armed.
   assign timer_run = (state_q == IBTO_RUN) && bus_busy && (sel != SEL_OFF) && scl_s;

   ibto_timer #(
      .W(CNT_W)
   ) u_timer (
      .clk(clk),
      .nrst(nrst),
      .run(timer_run),
      .clear(scl_rise),
      .tick(presc_tick),
      .limit(limit),
      .expire(expire)
   );

   always_comb begin
      state_d = state_q;
      case (state_q)
         IBTO_IDLE: begin
            if (bus_busy) state_d = IBTO_RUN;
         end
         IBTO_RUN: begin
            if (!bus_busy) state_d = IBTO_IDLE;
            else if (wr_abort) state_d = IBTO_STOPPED;
            else if (expire && go_idle_en) state_d = IBTO_STOPPED;
         end
         IBTO_STOPPED: begin
            if (!bus_busy) state_d = IBTO_IDLE;
         end
         default: state_d = IBTO_IDLE;
      endcase
   end

   // Flags: hardware set wins over a write-one clear in the same cycle.
   assign set_ev[IRQ_TIMEOUT_BIT] = expire;
   assign set_ev[IRQ_ABORT_BIT] = wr_abort;
   assign flags_d = (flags_q & ~(wr_flags ? reg_wdata[IRQ_W-1:0] : '0)) | set_ev;

   always_comb begin
      case (reg_addr)
         OFF_CTRL: rd_mux = ctrl_q;
         OFF_STATUS: rd_mux = {{(DATA_W-4){1'b0}}, scl_s, bus_busy, state_q};
         OFF_IRQ_FLAGS: rd_mux = {{(DATA_W-IRQ_W){1'b0}}, flags_q};
         OFF_IRQ_MASK: rd_mux = {{(DATA_W-IRQ_W){1'b0}}, mask_q};
         default: rd_mux = '0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         ctrl_q <= CTRL_RESET;
         flags_q <= '0;
         mask_q <= '0;
         state_q <= IBTO_IDLE;
         scl_prev_q <= 1'b1;
         reg_rdata <= '0;
         force_idle <= 1'b0;
         abort_cmd <= 1'b0;
         irq <= 1'b0;
      end else begin
         if (wr_ctrl) ctrl_q <= reg_wdata & CTRL_WMASK;
         if (wr_mask) mask_q <= reg_wdata[IRQ_W-1:0];
         flags_q <= flags_d;
         state_q <= state_d;
         scl_prev_q <= scl_s;
         reg_rdata <= reg_rd ? rd_mux : '0;
         // Go idle only when enabled; otherwise bus state is left alone.
         force_idle <= expire && go_idle_en && (state_q == IBTO_RUN);
         abort_cmd <= wr_abort;
         irq <= |(flags_d & mask_q);
      end
   end
endmodule
`default_nettype wire

// [rtl/ibto_pkg.sv]
// Purpose: Shared constants for the bus idle timeout block.
// Assumes: Registers are reached over a plain address/strobe port.
// Notes: Offsets are word indices times four.
package ibto_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_IRQ_FLAGS = 8'h08;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
   localparam logic [7:0] OFF_CMD = 8'h10;
   localparam int unsigned CTRL_GO_IDLE_BIT = 15;
   localparam int unsigned CTRL_SEL_LSB = 12;
   localparam int unsigned CTRL_SEL_MSB = 13;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] CTRL_WMASK = 32'h0000_b000;
   localparam int unsigned IRQ_TIMEOUT_BIT = 0;
   localparam int unsigned IRQ_ABORT_BIT = 1;
   localparam int unsigned IRQ_W = 2;
   localparam int unsigned CMD_ABORT_BIT = 0;
   localparam int unsigned CNT_W = 8;
   localparam logic [7:0] TIMEOUT_SHORT = 8'd40;
   localparam logic [7:0] TIMEOUT_MEDIUM = 8'd80;
   localparam logic [7:0] TIMEOUT_LONG = 8'd160;
   localparam logic [1:0] SEL_OFF = 2'h0;
   localparam logic [1:0] SEL_SHORT = 2'h1;
   localparam logic [1:0] SEL_MEDIUM = 2'h2;
   localparam logic [1:0] SEL_LONG = 2'h3;
   typedef enum logic [1:0] {
      IBTO_IDLE = 2'b00,
      IBTO_RUN = 2'b01,
      IBTO_STOPPED = 2'b11
   } ibto_state_t;
endpackage

// [rtl/ibto_sync.sv]
// Purpose: Two flip-flop synchroniser for one level.
// Assumes: Input is asynchronous to clk.
// Notes: The first stage feeds only the second.
`default_nettype none
module ibto_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Level
   input wire logic async_in,
   output logic sync_out
);
   logic meta_q;
   always_ff @(posedge clk) begin
      // Reset to the released line level so that no false rising edge follows reset.
      if (!nrst) begin
         meta_q <= 1'b1;
         sync_out <= 1'b1;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

// [rtl/ibto_timer.sv]
// Purpose: Idle timer counting prescaled ticks up to a selected limit.
// Assumes: tick is one clk cycle wide.
// Notes: Restarts on clear; wraps after each expiry.
`default_nettype none
module ibto_timer
   import ibto_pkg::*;
#(
   parameter int unsigned W = CNT_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Control
   input wire logic run,
   input wire logic clear,
   input wire logic tick,
   input wire logic [W-1:0] limit,
   // Result
   output logic expire
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic hit;
   // The longest selectable limit needs at least eight counter bits.
   if (W < 8) begin : g_width_check
      $error("ibto_timer: width too small for the longest limit");
   end
   assign hit = run && tick && (cnt_q + W'(1) >= limit);
   assign cnt_d = (clear || !run || hit) ? '0 : (tick ? cnt_q + W'(1) : cnt_q);
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cnt_q <= '0;
         expire <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         expire <= hit && !clear;
      end
   end
endmodule
`default_nettype wire

// [testbench/ibto_chk_asserts.sv]
// Purpose: Port checks for the idle timeout block.
// Assumes: Bound to ibto_top.
// Notes: One clock domain.
`default_nettype none
module ibto_chk
   import ibto_pkg::*;
(
   // Ports of the top
   input wire logic clk, nrst, reg_wr, reg_rd, presc_tick, bus_busy, scl_in,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata, reg_rdata,
   input wire logic force_idle, abort_cmd, irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   abort_echo_a:
      assert property (reg_wr && reg_addr == OFF_CMD && reg_wdata[0] |=> abort_cmd) else $error("abort lost");
   abort_src_a:
      assert property (abort_cmd |-> $past(reg_wr) && $past(reg_addr) == OFF_CMD) else $error("stray abort");
   idle_once_a:
      assert property (force_idle |=> !force_idle [*8]) else $error("idle repeated");
   idle_busy_a:
      assert property (force_idle |-> $past(bus_busy, 2)) else $error("idle while free");
   idle_tick_a:
      assert property (force_idle |-> $past(presc_tick, 2)) else $error("idle without tick");
   idle_scl_a:
      assert property (force_idle |-> $past(scl_in, 4)) else $error("idle with scl low");
   ctrl_resv_a:
      assert property (reg_rd && reg_addr == OFF_CTRL |=> (reg_rdata & ~CTRL_WMASK) == '0) else $error("ctrl bits");
   irq_mask_a:
      assert property (reg_wr && reg_addr == OFF_IRQ_MASK && reg_wdata[1:0] == 2'h0 |=> ##1 !irq) else $error("irq");
   cover property (force_idle);
   cover property (abort_cmd);
   cover property (irq);
endmodule
bind ibto_top ibto_chk u_ibto_chk (.*);
`default_nettype wire

// [testbench/ibto_scl_model.sv]
// Purpose: SCL as driven by the other bus parties.
// Assumes: Period zero leaves SCL released, pulled high.
// Notes: SCL is low two cycles once per period.
`default_nettype none
module ibto_scl_model (
   // Clock and pacing
   input wire logic clk,
   input wire logic [7:0] period,
   // Line
   output logic scl
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt = 8'h0;
   always @(posedge clk) cnt <= (period == 8'h0 || cnt + 8'h1 >= period) ? 8'h0 : cnt + 8'h1;
   assign scl = !(period != 8'h0 && cnt < 8'h2);
endmodule
`default_nettype wire

// [testbench/test_ibto_top.sv]
// Purpose: Register level test of the idle timeout block.
// Assumes: One prescaled tick every clock.
// Notes: Timeouts are probed a few cycles either side.
`default_nettype none
module test_ibto_top
   import ibto_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic nrst, reg_wr, reg_rd, presc_tick, bus_busy, scl_in, force_idle, abort_cmd, irq;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata;
   logic [7:0] per;
   int err_total = 0, checks = 0, fi_n = 0, lim;
   always #2 clk = ~clk;
   always @(posedge clk) if (force_idle) fi_n <= fi_n + 1;
   ibto_scl_model u_ibto_scl_model (.clk(clk), .period(per), .scl(scl_in));
   ibto_top u_ibto_top (.*);
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      chk(reg_rdata, e);
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      give_verdict();
   end
   initial begin
      {nrst, reg_wr, reg_rd, presc_tick, bus_busy} = 5'h0;
      reg_addr = '0;
      reg_wdata = '0;
      per = 8'h0;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      presc_tick <= 1'b1;
      rd(OFF_CTRL, CTRL_RESET);
      rd(8'h14, 32'h0);
      wr(OFF_IRQ_MASK, 32'h3);
      for (int i = 1; i < 4; i++) begin
         lim = 20 << i;
         wr(OFF_CTRL, 32'(i) << CTRL_SEL_LSB);
         bus_busy <= 1'b1;
         repeat (lim - 6) @(posedge clk);
         rd(OFF_IRQ_FLAGS, 32'h0);
         repeat (8) @(posedge clk);
         rd(OFF_IRQ_FLAGS, 32'h1);
         wr(OFF_IRQ_FLAGS, 32'h1);
         repeat (lim) @(posedge clk);
         rd(OFF_IRQ_FLAGS, 32'h1);
         rd(OFF_STATUS, 32'hd);
         wr(OFF_IRQ_FLAGS, 32'h1);
         per <= 8'(lim - 8);
         repeat (3 * lim) @(posedge clk);
         rd(OFF_IRQ_FLAGS, 32'h0);
         per <= 8'h0;
         bus_busy <= 1'b0;
         wr(OFF_IRQ_FLAGS, 32'h3);
         $display("select %0d done", i);
      end
      chk(fi_n, 0);
      wr(OFF_CTRL, 32'h9000);
      bus_busy <= 1'b1;
      repeat (130) @(posedge clk);
      chk(fi_n, 1);
      rd(OFF_STATUS, 32'hf);
      bus_busy <= 1'b0;
      repeat (2) @(posedge clk);
      rd(OFF_STATUS, 32'h8);
      bus_busy <= 1'b1;
      wr(OFF_IRQ_FLAGS, 32'h3);
      wr(OFF_CMD, 32'h1);
      rd(OFF_STATUS, 32'hf);
      rd(OFF_IRQ_FLAGS, 32'h2);
      chk(irq, 1'b1);
      wr(OFF_IRQ_MASK, 32'h0);
      @(posedge clk);
      @(posedge clk);
      chk(irq, 1'b0);
      $display("go idle and abort done");
      bus_busy <= 1'b0;
      wr(OFF_IRQ_FLAGS, 32'h3);
      wr(OFF_CTRL, 32'h0);
      bus_busy <= 1'b1;
      repeat (200) @(posedge clk);
      rd(OFF_IRQ_FLAGS, 32'h0);
      $display("select off done");
      give_verdict();
   end
endmodule
`default_nettype wire
